// [osd_clock_control.sv]
// Oscillator selection, switch sequencing and clock divider registers
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "osd_params.svh"
module osd_clock_control
  import osd_pkg::*;
#(
  parameter int ADDR_W = 2,
  parameter int DATA_W = 16
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic [1:0] primary_mode_cfg,
  input wire logic [2:0] initial_source_cfg,
  input wire logic one_way_pin_lock_cfg,
  input wire logic clock_failure_detect,
  input wire logic source_ready,
  input wire logic multiplier_locked,
  input wire logic new_clock_tick,
  input wire logic interrupt_event,
  input wire logic sleep_mode,
  output logic [2:0] active_source,
  output logic [1:0] primary_submode,
  output logic primary_osc_on,
  output logic secondary_osc_on,
  output logic fail_safe_monitor_on,
  output logic pin_mapping_lock,
  output logic switching_busy,
  output logic peripheral_ratio_tick,
  output logic fast_rc_post_tick,
  output logic [`OSD_TRIM_W-1:0] fast_rc_trim
);
  initial
  begin
    if (DATA_W != 16 || ADDR_W < 2)
      $error("osd_clock_control: unsupported bus widths");
  end

  // ************************************************************
  // Configuration decode
  // ************************************************************
  logic switching_allowed;
  logic monitor_on;
  logic [2:0] cfg_source;
  assign switching_allowed = ~switch_monitor_cfg[1];
  assign monitor_on = (switch_monitor_cfg == 2'h0);
  assign fail_safe_monitor_on = monitor_on;
  // Erased fuses read all ones, selecting fast RC with postscaler
  assign cfg_source = initial_source_cfg;

  function automatic logic uses_primary(input logic [2:0] src);
    uses_primary = (src == OSD_SRC_PRIMARY) || (src == OSD_SRC_PRIMARY_MULT);
  endfunction : uses_primary

  function automatic logic uses_multiplier(input logic [2:0] src);
    uses_multiplier = (src == OSD_SRC_PRIMARY_MULT) ||
                      (src == OSD_SRC_FAST_RC_MULT);
  endfunction : uses_multiplier

  // ************************************************************
  // Register state
  // ************************************************************
  logic [2:0] current_source_sel;
  logic [2:0] next_source_sel;
  logic clock_selection_lock;
  logic pin_lock;
  logic clock_fail_flag;
  logic primary_run_in_sleep;
  logic secondary_osc_enable;
  logic switch_request;
  logic wake_restore_ratio;
  logic [2:0] peripheral_ratio;
  logic ratio_reduce_enable;
  logic [2:0] fast_rc_postscale;
  logic [`OSD_TRIM_W-1:0] trim;
  logic settled_timer_done;
  logic cfg_loaded;
  osd_switch_state_type sw_state;
  logic [3:0] wait_count;

  // ************************************************************
  // Write decode and unlock
  // ************************************************************
  logic wr_ctrl;
  logic wr_div;
  logic wr_trim;
  logic wr_unlock;
  logic high_open;
  logic low_open;
  logic high_ok;
  logic low_ok;
  assign wr_ctrl = reg_write && reg_addr == `OSD_OFS_OSC_CONTROL;
  assign wr_div = reg_write && reg_addr == `OSD_OFS_DIVIDER;
  assign wr_trim = reg_write && reg_addr == `OSD_OFS_TRIM;
  assign wr_unlock = reg_write && reg_addr == `OSD_OFS_UNLOCK;
  assign high_ok = wr_ctrl && high_open;
  assign low_ok = wr_ctrl && low_open;

  // Keys go to the unlock port: high keys in [15:8], low keys in [7:0]
  osd_unlock u_high_unlock
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .key_write(wr_unlock),
    .key_byte(reg_wdata[15:8]),
    .key_first(`OSD_KEY_HIGH_A),
    .key_second(`OSD_KEY_HIGH_B),
    .consume(wr_ctrl),
    .open(high_open)
  );

  osd_unlock u_low_unlock
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .key_write(wr_unlock),
    .key_byte(reg_wdata[7:0]),
    .key_first(`OSD_KEY_LOW_A),
    .key_second(`OSD_KEY_LOW_B),
    .consume(wr_ctrl),
    .open(low_open)
  );

  // ************************************************************
  // Switch sequencing
  // ************************************************************
  logic sel_locked;
  logic start_switch;
  logic redundant;
  logic switch_done;
  logic [2:0] next_current;
  assign sel_locked = monitor_on && clock_selection_lock;
  assign start_switch = low_ok && reg_wdata[`OSD_SWITCH_BIT] &&
                        switching_allowed && !sel_locked &&
                        sw_state == OSD_SW_IDLE;
  assign redundant = start_switch &&
                     next_source_sel == current_source_sel;
  assign switch_done = sw_state == OSD_SW_COUNT && new_clock_tick &&
                       wait_count == 4'(`OSD_SWITCH_WAIT_CYC - 1);
  assign next_current = switch_done ? next_source_sel
                                    : current_source_sel;
  assign switching_busy = sw_state != OSD_SW_IDLE;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sw_state <= OSD_SW_IDLE;
      wait_count <= 4'h0;
    end
    else
    begin
      unique case (sw_state)
        OSD_SW_IDLE:
        begin
          wait_count <= 4'h0;
          if (start_switch && !redundant)
            sw_state <= OSD_SW_WAIT_READY;
        end
        OSD_SW_WAIT_READY:
          if (source_ready && (!uses_multiplier(next_source_sel) ||
              multiplier_locked))
            sw_state <= OSD_SW_COUNT;
        OSD_SW_COUNT:
          if (switch_done)
            sw_state <= OSD_SW_IDLE;
          else if (new_clock_tick)
            wait_count <= wait_count + 4'h1;
      endcase
    end
  end

  // ************************************************************
  // Oscillator control register
  // ************************************************************
  logic next_fail;
  logic next_pin_lock;
  logic pin_lock_may_clear;
  assign pin_lock_may_clear = !(one_way_pin_lock_cfg && pin_lock);
  assign next_pin_lock = (low_ok && (reg_wdata[`OSD_PIN_LOCK_BIT] ||
                         pin_lock_may_clear)) ?
                         reg_wdata[`OSD_PIN_LOCK_BIT] : pin_lock;
  // Hardware set wins over a same-cycle software clear
  assign next_fail = (clock_failure_detect && monitor_on) ||
                     (clock_fail_flag && !(low_ok &&
                     !reg_wdata[`OSD_FAIL_BIT]));

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg_loaded <= 1'b0;
      current_source_sel <= OSD_SRC_FAST_RC_POST;
      next_source_sel <= OSD_SRC_FAST_RC_POST;
      clock_selection_lock <= 1'b0;
      pin_lock <= 1'b0;
      clock_fail_flag <= 1'b0;
      primary_run_in_sleep <= 1'b0;
      secondary_osc_enable <= 1'b0;
      switch_request <= 1'b0;
    end
    else if (!cfg_loaded)
    begin
      // Configuration fields are caught on the first edge after reset
      cfg_loaded <= 1'b1;
      current_source_sel <= cfg_source;
      next_source_sel <= cfg_source;
    end
    else
    begin
      current_source_sel <= next_current;
      if (high_ok && !sel_locked && !switching_busy)
        next_source_sel <= reg_wdata[`OSD_NEXT_SRC_LSB +: 3];
      if (low_ok && reg_wdata[`OSD_CLK_LOCK_BIT])
        clock_selection_lock <= 1'b1;
      pin_lock <= next_pin_lock;
      clock_fail_flag <= next_fail;
      if (low_ok)
      begin
        primary_run_in_sleep <= reg_wdata[`OSD_RUN_SLEEP_BIT];
        secondary_osc_enable <= reg_wdata[`OSD_SEC_EN_BIT];
      end
      if (!switching_allowed || switch_done || redundant)
        switch_request <= 1'b0;
      else if (start_switch)
        switch_request <= 1'b1;
    end
  end

  // ************************************************************
  // Multiplier settled flag
  // ************************************************************
  logic valid_switch;
  assign valid_switch = start_switch && !redundant;

  always_ff @(posedge ref_clk)
  begin
    if (rst || valid_switch || !uses_multiplier(current_source_sel))
      settled_timer_done <= 1'b0;
    else
      settled_timer_done <= multiplier_locked;
  end

  // ************************************************************
  // Divider and trim registers
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wake_restore_ratio <= 1'b0;
      peripheral_ratio <= 3'h0;
      ratio_reduce_enable <= 1'b0;
      fast_rc_postscale <= `OSD_POST_RESET;
      trim <= '0;
    end
    else
    begin
      if (wr_div)
      begin
        wake_restore_ratio <= reg_wdata[`OSD_RESTORE_BIT];
        peripheral_ratio <= reg_wdata[`OSD_RATIO_LSB +: 3];
        fast_rc_postscale <= reg_wdata[`OSD_POST_LSB +: 3];
      end
      if (wake_restore_ratio && interrupt_event)
        ratio_reduce_enable <= 1'b0;
      else if (wr_div)
        ratio_reduce_enable <= reg_wdata[`OSD_REDUCE_BIT];
      if (wr_trim)
        trim <= reg_wdata[`OSD_TRIM_W-1:0];
    end
  end

  // ************************************************************
  // Clock ratio and postscaler ticks
  // ************************************************************
  logic [2:0] eff_ratio;
  assign eff_ratio = ratio_reduce_enable ? peripheral_ratio : 3'h0;

  osd_ratio_div #(.CODE_W(3), .CNT_W(8)) u_periph_div
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .log2_div(eff_ratio),
    .code_max_256(1'b0),
    .tick(peripheral_ratio_tick)
  );

  osd_ratio_div #(.CODE_W(3), .CNT_W(8)) u_post_div
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .log2_div(fast_rc_postscale),
    .code_max_256(fast_rc_postscale == 3'h7),
    .tick(fast_rc_post_tick)
  );

  // ************************************************************
  // Oscillator enables and status outputs
  // ************************************************************
  assign active_source = current_source_sel;
  assign primary_submode = uses_primary(current_source_sel) ?
                           primary_mode_cfg : OSD_PRI_OFF;
  assign primary_osc_on = (uses_primary(current_source_sel) ||
                           (switching_busy && uses_primary(next_source_sel)))
                          && (!sleep_mode || primary_run_in_sleep);
  assign secondary_osc_on = secondary_osc_enable ||
                            current_source_sel == OSD_SRC_SECONDARY;
  assign pin_mapping_lock = pin_lock;
  assign fast_rc_trim = trim;

  // ************************************************************
  // Read back, one cycle after the strobe
  // ************************************************************
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] div_word;
  logic [DATA_W-1:0] read_mux;
  assign ctrl_word = {1'b0, current_source_sel, 1'b0, next_source_sel,
                      clock_selection_lock, pin_lock, settled_timer_done,
                      1'b0, clock_fail_flag, primary_run_in_sleep,
                      secondary_osc_enable, switch_request};
  assign div_word = {wake_restore_ratio, peripheral_ratio,
                     ratio_reduce_enable, fast_rc_postscale, 8'h00};
  assign read_mux = (reg_addr == `OSD_OFS_OSC_CONTROL) ? ctrl_word :
                    (reg_addr == `OSD_OFS_DIVIDER) ? div_word :
                    (reg_addr == `OSD_OFS_TRIM) ?
                    {10'h000, trim} : 16'h0000;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_read)
      reg_rdata <= read_mux;
    else
      reg_rdata <= 16'h0000;
  end
endmodule : osd_clock_control
`default_nettype wire

// [osd_clock_control_assertions.sv]
// Port checks for the clock control block
`timescale 1ns/100ps
`default_nettype none
module osd_clock_control_assertions
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic [1:0] primary_mode_cfg,
  input wire logic clock_failure_detect,
  input wire logic new_clock_tick,
  input wire logic [2:0] active_source,
  input wire logic [1:0] primary_submode,
  input wire logic secondary_osc_on,
  input wire logic fail_safe_monitor_on,
  input wire logic switching_busy
);
  // **********
  // Properties
  // **********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_fail_seen;
    clock_failure_detect && fail_safe_monitor_on && !switching_busy;
  endsequence
  sequence s_ctl_read;
    reg_read && reg_addr == 2'h0;
  endsequence
  chk_trim_zero: assert property (
    $past(reg_read) && $past(reg_addr) == 2'h2 |-> reg_rdata[15:6] == 10'h0)
    else $error("trim upper bits not zero");
  chk_monitor_cfg: assert property (
    fail_safe_monitor_on == (switch_monitor_cfg == 2'h0))
    else $error("monitor enable wrong");
  chk_submode_pick: assert property (
    primary_submode == ((active_source[2:1] == 2'h1) ? primary_mode_cfg : 2'h3))
    else $error("primary submode wrong");
  chk_no_sw_busy: assert property (
    switch_monitor_cfg[1] |-> !switching_busy)
    else $error("switch ran while disabled");
  chk_src_frozen: assert property (
    switch_monitor_cfg[1] && !$past(rst) && !$past(rst, 2)
    |-> $stable(active_source))
    else $error("source moved while switching disabled");
  chk_src_on_tick: assert property (
    !$past(rst) && !$past(rst, 2) && $changed(active_source)
    |-> $past(new_clock_tick))
    else $error("source changed without new clock edge");
  chk_src_write_ro: assert property (
    reg_write && !switching_busy |=> $stable(active_source))
    else $error("write changed current source");
  chk_fail_sticky: assert property (
    s_fail_seen ##1 s_ctl_read |=> reg_rdata[3])
    else $error("fail flag not set");
  chk_sec_enable: assert property (
    $past(reg_read) && $past(reg_addr) == 2'h0
    |-> secondary_osc_on == (reg_rdata[1] || reg_rdata[14:12] == 3'h4))
    else $error("secondary enable mismatch");
  chk_busy_ends: assert property (
    $rose(switching_busy) |-> ##[1:400] !switching_busy)
    else $error("switch never completed");
endmodule : osd_clock_control_assertions
bind osd_clock_control osd_clock_control_assertions chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .switch_monitor_cfg(switch_monitor_cfg),
  .primary_mode_cfg(primary_mode_cfg),
  .clock_failure_detect(clock_failure_detect),
  .new_clock_tick(new_clock_tick), .active_source(active_source),
  .primary_submode(primary_submode), .secondary_osc_on(secondary_osc_on),
  .fail_safe_monitor_on(fail_safe_monitor_on),
  .switching_busy(switching_busy));
`default_nettype wire

// [osd_clock_control_bench.sv]
// Self-checking bench for the clock control block
`timescale 1ns/100ps
`default_nettype none
module osd_clock_control_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [1:0] sm_cfg = 2'h3;
  logic [1:0] pm_cfg = 2'h0;
  logic [2:0] init_cfg = 3'h7;
  logic one_way = 1'b0;
  logic fail_det = 1'b0;
  logic irq = 1'b0;
  logic slow = 1'b0;
  logic [15:0] reg_rdata;
  logic src_rdy, mul_lock, nc_tick, busy, pin_lock, r_tick, p_tick;
  logic [7:0] m_lo;
  int m_cur, m_nxt, error_cnt = 0, n_compared = 0;
  osd_clock_control dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .switch_monitor_cfg(sm_cfg), .primary_mode_cfg(pm_cfg),
    .initial_source_cfg(init_cfg), .one_way_pin_lock_cfg(one_way),
    .clock_failure_detect(fail_det), .source_ready(src_rdy),
    .multiplier_locked(mul_lock), .new_clock_tick(nc_tick),
    .interrupt_event(irq), .sleep_mode(1'b0), .active_source(),
    .primary_submode(), .primary_osc_on(), .secondary_osc_on(),
    .fail_safe_monitor_on(), .pin_mapping_lock(pin_lock),
    .switching_busy(busy), .peripheral_ratio_tick(r_tick),
    .fast_rc_post_tick(p_tick), .fast_rc_trim());
  osd_osc_model osc (.ref_clk(ref_clk), .rst(rst), .switching_busy(busy),
    .slow(slow), .source_ready(src_rdy), .multiplier_locked(mul_lock),
    .new_clock_tick(nc_tick));
  initial forever #4 ref_clk = ~ref_clk;
  // **********
  // Tasks
  // **********
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    reg_read <= 1'b0;
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask : wr
  task automatic chk_rd(input logic [1:0] a, input logic [15:0] e);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    check(reg_rdata, e);
    @(posedge ref_clk);
  endtask : chk_rd
  function automatic logic [15:0] ctl_exp();
    logic st;
    st = (m_cur == 1 || m_cur == 3);
    return {1'b0, m_cur[2:0], 1'b0, m_nxt[2:0], m_lo[7:6], st, m_lo[4:0]};
  endfunction : ctl_exp
  task automatic ctl_lo(input logic [7:0] v);
    wr(2'h3, 16'h0046);
    wr(2'h3, 16'h0057);
    wr(2'h0, {8'h00, v});
    m_lo[7] = m_lo[7] | v[7];
    if (!(one_way && m_lo[6]))
      m_lo[6] = v[6];
    m_lo[3] = m_lo[3] & v[3];
    m_lo[2:1] = v[2:1];
  endtask : ctl_lo
  task automatic sw(input int n);
    logic lk;
    int k;
    lk = (sm_cfg == 2'h0) && m_lo[7];
    wr(2'h3, 16'h7800);
    wr(2'h3, 16'h9A00);
    wr(2'h0, {5'h00, n[2:0], 8'h00});
    ctl_lo(m_lo | 8'h01);
    if (!lk)
      m_nxt = n;
    if (!sm_cfg[1] && !lk)
      m_cur = m_nxt;
    idle(2);
    for (k = 0; k < 500 && busy !== 1'b0; k++)
      @(negedge ref_clk);
    if (k == 500)
    begin
      error_cnt++;
      results();
    end
    @(posedge ref_clk);
  endtask : sw
  task automatic pulse_in(input int which);
    if (which == 0)
      fail_det <= 1'b1;
    else
      irq <= 1'b1;
    idle(1);
    fail_det <= 1'b0;
    irq <= 1'b0;
  endtask : pulse_in
  // **********
  // Sequence
  // **********
  initial
  begin
    int rc, pc;
    logic [15:0] r;
    void'($urandom(32'hD05486DB));
    for (int p = 0; p < 3; p++)
    begin
      rst <= 1'b1;
      sm_cfg <= (p == 0) ? 2'h3 : (p == 1) ? 2'h1 : 2'h0;
      init_cfg <= (p == 0) ? 3'h7 : (p == 1) ? 3'h5 : 3'h2;
      pm_cfg <= 2'($urandom % 3);
      one_way <= (p == 2);
      slow <= (p == 1);
      idle(2);
      rst <= 1'b0;
      idle(2);
      m_cur = (p == 0) ? 7 : (p == 1) ? 5 : 2;
      m_nxt = m_cur;
      m_lo = 8'h00;
      chk_rd(2'h0, ctl_exp());
      chk_rd(2'h1, 16'h0100);
      chk_rd(2'h2, 16'h0000);
      chk_rd(2'h3, 16'h0000);
      wr(2'h0, 16'h0306);
      chk_rd(2'h0, ctl_exp());
      for (int t = 0; t < 8; t++)
        if (t != 6)
        begin
          sw(t);
          chk_rd(2'h0, ctl_exp());
        end
      sw(m_cur);
      chk_rd(2'h0, ctl_exp());
      ctl_lo(m_lo | 8'h80);
      sw(0);
      chk_rd(2'h0, ctl_exp());
      ctl_lo(m_lo | 8'h40);
      idle(1);
      @(negedge ref_clk);
      check({15'h0, pin_lock}, 16'h0001);
      @(posedge ref_clk);
      ctl_lo(m_lo & 8'hBF);
      idle(1);
      @(negedge ref_clk);
      check({15'h0, pin_lock}, {15'h0, m_lo[6]});
      @(posedge ref_clk);
      pulse_in(0);
      m_lo[3] = (sm_cfg == 2'h0);
      chk_rd(2'h0, ctl_exp());
      ctl_lo(m_lo & 8'hF7);
      chk_rd(2'h0, ctl_exp());
      r = 16'($urandom);
      wr(2'h2, r);
      chk_rd(2'h2, r & 16'h003F);
      wr(2'h1, 16'hDBFF);
      chk_rd(2'h1, 16'hDB00);
      pulse_in(1);
      chk_rd(2'h1, 16'hD300);
      wr(2'h1, 16'h5B00);
      pulse_in(1);
      chk_rd(2'h1, 16'h5B00);
      $display("test %0d done", p);
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(2'h1, {1'b0, 3'(k), 1'(k), 3'(k), 8'h00});
      idle(300);
      rc = 0;
      pc = 0;
      repeat (512)
      begin
        @(negedge ref_clk);
        rc += (r_tick === 1'b1);
        pc += (p_tick === 1'b1);
      end
      check(16'(rc), (k % 2) ? 16'(512 >> k) : 16'd512);
      check(16'(pc), 16'(512 / ((k == 7) ? 256 : (1 << k))));
      @(posedge ref_clk);
    end
    $display("test ratio done");
    results();
  end
endmodule : osd_clock_control_bench
`default_nettype wire

// [osd_osc_model.sv]
// Behavioural oscillator sources behind the clock control block
`timescale 1ns/100ps
`default_nettype none
module osd_osc_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic switching_busy,
  input wire logic slow,
  output logic source_ready,
  output logic multiplier_locked,
  output logic new_clock_tick
);
  // **********
  // Start-up
  // **********
  logic busy_q = 1'b0;
  int wait_cnt = 0;
  int tick_cnt = 0;
  always_ff @(posedge ref_clk)
  begin
    busy_q <= switching_busy;
    tick_cnt <= (tick_cnt + 1) % 3;
    new_clock_tick <= (tick_cnt == 0);
    if (rst)
    begin
      wait_cnt <= 0;
      source_ready <= 1'b1;
      multiplier_locked <= 1'b1;
    end
    else if (switching_busy && !busy_q)
    begin
      wait_cnt <= slow ? 20 : 2;
      source_ready <= 1'b0;
      multiplier_locked <= 1'b0;
    end
    else if (wait_cnt > 0)
    begin
      wait_cnt <= wait_cnt - 1;
      source_ready <= (wait_cnt == 1);
      multiplier_locked <= (wait_cnt == 1);
    end
  end
endmodule : osd_osc_model
`default_nettype wire

// [osd_params.svh]
// Offsets, field positions, reset values and timing counts for clock control
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH

// ************************************************************
// Register offsets (word index on the plain register port)
// ************************************************************
`define OSD_OFS_OSC_CONTROL 2'h0
`define OSD_OFS_DIVIDER 2'h1
`define OSD_OFS_TRIM 2'h2
`define OSD_OFS_UNLOCK 2'h3

// ************************************************************
// Oscillator control fields
// ************************************************************
`define OSD_CUR_SRC_LSB 12
`define OSD_NEXT_SRC_LSB 8
`define OSD_CLK_LOCK_BIT 7
`define OSD_PIN_LOCK_BIT 6
`define OSD_SETTLED_BIT 5
`define OSD_FAIL_BIT 3
`define OSD_RUN_SLEEP_BIT 2
`define OSD_SEC_EN_BIT 1
`define OSD_SWITCH_BIT 0

// ************************************************************
// Divider and trim fields
// ************************************************************
`define OSD_RESTORE_BIT 15
`define OSD_RATIO_LSB 12
`define OSD_REDUCE_BIT 11
`define OSD_POST_LSB 8
`define OSD_POST_RESET 3'h1
`define OSD_TRIM_W 6

// ************************************************************
// Unlock keys and timing
// ************************************************************
`define OSD_KEY_HIGH_A 8'h78
`define OSD_KEY_HIGH_B 8'h9A
`define OSD_KEY_LOW_A 8'h46
`define OSD_KEY_LOW_B 8'h57
`define OSD_SWITCH_WAIT_CYC 10
`define OSD_FAST_RC_MHZ 8

`endif

// [osd_pkg.sv]
// Types shared by the clock control block
package osd_pkg;
  typedef enum logic [2:0] {
    OSD_SRC_FAST_RC = 3'h0,
    OSD_SRC_FAST_RC_MULT = 3'h1,
    OSD_SRC_PRIMARY = 3'h2,
    OSD_SRC_PRIMARY_MULT = 3'h3,
    OSD_SRC_SECONDARY = 3'h4,
    OSD_SRC_LOW_POWER_RC = 3'h5,
    OSD_SRC_RESERVED = 3'h6,
    OSD_SRC_FAST_RC_POST = 3'h7
  } osd_source_type;

  typedef enum logic [1:0] {
    OSD_PRI_EXTERNAL_CLOCK_IN = 2'h0,
    OSD_PRI_CRYSTAL_MEDIUM = 2'h1,
    OSD_PRI_CRYSTAL_HIGH_SPEED = 2'h2,
    OSD_PRI_OFF = 2'h3
  } osd_primary_type;

  typedef enum {
    OSD_SW_IDLE,
    OSD_SW_WAIT_READY,
    OSD_SW_COUNT
  } osd_switch_state_type;
endpackage : osd_pkg

// [osd_ratio_div.sv]
// Power-of-two clock enable divider
`timescale 1ns/100ps
`default_nettype none
module osd_ratio_div
  import osd_pkg::*;
#(
  parameter int CODE_W = 3,
  parameter int CNT_W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [CODE_W-1:0] log2_div,
  input wire logic code_max_256,
  output logic tick
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] next_count;

  initial
  begin
    if (CODE_W < 1 || CNT_W < 8 || CNT_W < (1 << CODE_W) - 1)
      $error("osd_ratio_div: counter too narrow");
  end

  // ************************************************************
  // Tick once every 2**code reference cycles, or every 2**CNT_W cycles when code_max_256 is set
  // ************************************************************
  assign limit = code_max_256 ? {CNT_W{1'b1}}
               : CNT_W'((1 << log2_div) - 1);
  assign next_count = (count >= limit) ? '0 : count + 1'b1;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick <= (count >= limit);
    end
  end
endmodule : osd_ratio_div
`default_nettype wire

// [osd_unlock.sv]
// Unlock key detector for the protected byte writes
`timescale 1ns/100ps
`default_nettype none
`include "osd_params.svh"
module osd_unlock
  import osd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic key_write,
  input wire logic [7:0] key_byte,
  input wire logic [7:0] key_first,
  input wire logic [7:0] key_second,
  input wire logic consume,
  output logic open
);
  logic seen_first;
  logic next_seen_first;
  logic next_open;

  // ************************************************************
  // Keys must arrive back to back; any other write restarts
  // ************************************************************
  assign next_seen_first = key_write && (key_byte == key_first);
  assign next_open = key_write ? (seen_first && key_byte == key_second)
                               : (open && !consume);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      seen_first <= 1'b0;
      open <= 1'b0;
    end
    else
    begin
      seen_first <= next_seen_first;
      open <= next_open;
    end
  end
endmodule : osd_unlock
`default_nettype wire
